// ==== include/pwt_defines.vh ====
// register map, field positions, reset values and timing counts of the pwm timer unit
`ifndef PWT_DEFINES_VH
`define PWT_DEFINES_VH

// ==========================================================
// register offsets
`define PWT_ADDR_OUT_EN 8'hcf
`define PWT_ADDR_CTL_MAIN 8'hd2
`define PWT_ADDR_PER_MAIN_LO 8'hd3
`define PWT_ADDR_PER_MAIN_HI 8'hd4
`define PWT_ADDR_DUTY_MAIN_LO 8'hd5
`define PWT_ADDR_DUTY_MAIN_HI 8'hd6
`define PWT_ADDR_CTL_AUX_A 8'hd9
`define PWT_ADDR_PER_AUX_A 8'hda
`define PWT_ADDR_DUTY_AUX_A 8'hdb
`define PWT_ADDR_CTL_AUX_B 8'hdd
`define PWT_ADDR_PER_AUX_B 8'hde
`define PWT_ADDR_DUTY_AUX_B 8'hdf
`define PWT_ADDR_LOCK 8'he7

// ==========================================================
// control register fields
`define PWT_CTL_IE 7
`define PWT_CTL_OVF 6
`define PWT_CTL_FLT_STS 4
`define PWT_CTL_FLT_POL 3
`define PWT_CTL_POL 2
`define PWT_CTL_CKS_HI 1
`define PWT_CTL_CKS_LO 0

// ==========================================================
// output enable register fields
`define PWT_EN_FAULT 6
`define PWT_EN_COMP_LO 3
`define PWT_EN_PRIM_HI 2

// ==========================================================
// reset values and constants
`define PWT_RST_BYTE 8'h00
`define PWT_LOCK_KEY 8'h55
`define PWT_EN_DELAY_CLKS 3

`endif

// ==== rtl/pwt_top.v ====
// pwm timer unit: one 12-bit and two 8-bit channels, fault shutdown and write lock
`timescale 1ns/1ns
`include "pwt_defines.vh"
// ==========================================================
// Summary of operation
// - fault enable bit set makes the shared pin the fault input, else plain pin
// - enable bits 5..0 each give one primary or complementary pin to the pwm
// - output drives three clocks after enable set, stops the cycle it clears
// - with fault enable clear the fault pin level affects nothing
// - enable, control, period, duty writes land only while lock holds 0x55
// - polarity, clock select, period, duty writes to a running channel apply at next period
// - channel bit 7 enables its interrupt, gated by the group interrupt enable
// - channel bit 6 flag set on period overflow, held until software writes 0
// - valid fault sets fault status and holds outputs inactive until cleared
// - fault polarity 0 means low pin level faults, 1 means high level faults
// - fault bits act on all channels; main polarity and clock only on main
// - inactive outputs sit low for polarity 0 and high for polarity 1
// - fault forces inactive at once; resume at next period after status clear
// - clearing fault status while fault level is present has no effect
// - channel bit 2 polarity: 0 duty portion high, 1 duty portion low
// - clock select 00,01,10,11 divides the clock by 2,4,8,16
// - main period is a 12-bit value split in low byte and high nibble
// - period zero gives low output for polarity 0, high for polarity 1
// - main duty is a 12-bit value split in low byte and high nibble
// - nonzero period not above duty gives high for polarity 0, low for polarity 1
// - both 8-bit channels have the same enable, flag, polarity and divider
module pwt_top (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // interrupt
    input wire pwm_group_irq_enable,
    output reg pwm_irq,
    // fault input
    input wire fault_pin,
    output reg fault_pin_claim,
    // pwm pins, index 0 main, 1 aux a, 2 aux b
    output reg [2:0] pwm_out,
    output reg [2:0] pwm_out_oe,
    output reg [2:0] comp_out,
    output reg [2:0] comp_out_oe
);

    // ==========================================================
    // clock divide tick
    function pwt_tick;
        input [1:0] sel;
        input [3:0] pre;
        begin
            case (sel)
                2'b00: pwt_tick = pre[0];
                2'b01: pwt_tick = (pre[1:0] == 2'b11);
                2'b10: pwt_tick = (pre[2:0] == 3'b111);
                default: pwt_tick = (pre == 4'hf);
            endcase
        end
    endfunction

    // ==========================================================
    // write strobe decode that honours the lock
    function pwt_hit;
        input wr;
        input ok;
        input [7:0] addr;
        input [7:0] target;
        begin
            pwt_hit = wr && ok && (addr == target);
        end
    endfunction

    // ==========================================================
    // state
    reg [6:0] en_r;
    reg [5:0] st1_r;
    reg [5:0] st2_r;
    reg [7:0] lock_r;
    reg [3:0] pre_r;
    reg fault_pol_r;
    reg fault_sts_r;
    reg [2:0] ie_r;
    reg [2:0] ovf_r;
    reg [2:0] pol_sw_r;
    reg [2:0] pol_r;
    reg [1:0] cks_sw_r [0:2];
    reg [1:0] cks_r [0:2];
    reg [11:0] per_sw_r [0:2];
    reg [11:0] per_r [0:2];
    reg [11:0] duty_sw_r [0:2];
    reg [11:0] duty_r [0:2];
    reg [11:0] cnt_r [0:2];
    reg [2:0] hold_r;

    reg [6:0] en_nxt;
    reg [2:0] run_w;
    reg [2:0] tick_w;
    reg [2:0] wrap_w;
    reg [2:0] load_w;
    reg [2:0] wave_w;
    reg [2:0] off_w;
    reg [2:0] ctl_wr_w;
    reg lock_ok;
    reg fault_act;
    reg [2:0] ovf_nxt;
    reg [2:0] hold_nxt;
    reg [11:0] cnt_nxt [0:2];
    reg fault_sts_nxt;
    reg [2:0] pwm_nxt;
    reg [2:0] comp_nxt;
    reg irq_nxt;
    reg [7:0] rdata_nxt;
    // one loop index per process, none shared
    integer i;
    integer n;
    integer j;
    integer k;

    // ==========================================================
    // write qualification and channel timing
    always @* begin
        lock_ok = (lock_r == `PWT_LOCK_KEY);
        en_nxt = en_r;
        if (pwt_hit(reg_wr, lock_ok, reg_addr, `PWT_ADDR_OUT_EN)) begin
            en_nxt = reg_wdata[6:0];
        end
        ctl_wr_w[0] = pwt_hit(reg_wr, lock_ok, reg_addr, `PWT_ADDR_CTL_MAIN);
        ctl_wr_w[1] = pwt_hit(reg_wr, lock_ok, reg_addr, `PWT_ADDR_CTL_AUX_A);
        ctl_wr_w[2] = pwt_hit(reg_wr, lock_ok, reg_addr, `PWT_ADDR_CTL_AUX_B);
        // pin level ignored unless the pin belongs to the pwm
        fault_act = en_r[`PWT_EN_FAULT] && (fault_pin == fault_pol_r);
        for (i = 0; i < 3; i = i + 1) begin
            run_w[i] = en_r[i] | en_r[i + 3];
            tick_w[i] = pwt_tick(cks_r[i], pre_r);
            wrap_w[i] = run_w[i] && tick_w[i]
                && ((per_r[i] == 12'h000) || (cnt_r[i] >= per_r[i] - 12'h001));
            load_w[i] = ~run_w[i] | wrap_w[i];
            wave_w[i] = ((per_r[i] != 12'h000)
                && ((duty_r[i] >= per_r[i]) || (cnt_r[i] < duty_r[i]))) ^ pol_r[i];
            off_w[i] = hold_r[i] | fault_act | fault_sts_r;
        end
    end

    // ==========================================================
    // next values of counters, pins and sticky flags
    always @* begin
        for (n = 0; n < 3; n = n + 1) begin
            if (!run_w[n] || wrap_w[n]) begin
                cnt_nxt[n] = 12'h000;
            end else if (tick_w[n]) begin
                cnt_nxt[n] = cnt_r[n] + 12'h001;
            end else begin
                cnt_nxt[n] = cnt_r[n];
            end
            // outputs stay inactive until a period boundary after the fault status clears
            if (fault_act || fault_sts_r) begin
                hold_nxt[n] = 1'b1;
            end else if (load_w[n]) begin
                hold_nxt[n] = 1'b0;
            end else begin
                hold_nxt[n] = hold_r[n];
            end
            // a wrap in the cycle of a clearing write keeps the flag set
            if (wrap_w[n]) begin
                ovf_nxt[n] = 1'b1;
            end else if (ctl_wr_w[n]) begin
                ovf_nxt[n] = reg_wdata[`PWT_CTL_OVF];
            end else begin
                ovf_nxt[n] = ovf_r[n];
            end
            if (off_w[n]) begin
                pwm_nxt[n] = pol_r[n];
                comp_nxt[n] = pol_r[n];
            end else begin
                pwm_nxt[n] = wave_w[n];
                comp_nxt[n] = ~wave_w[n];
            end
        end
        // a present fault keeps the status set against a clearing write
        if (fault_act) begin
            fault_sts_nxt = 1'b1;
        end else if (ctl_wr_w[0]) begin
            fault_sts_nxt = reg_wdata[`PWT_CTL_FLT_STS];
        end else begin
            fault_sts_nxt = fault_sts_r;
        end
        irq_nxt = 1'b0;
        if (pwm_group_irq_enable && ((ie_r & ovf_r) != 3'h0)) begin
            irq_nxt = 1'b1;
        end
    end

    // ==========================================================
    // register file
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            en_r <= 7'h00;
            lock_r <= `PWT_RST_BYTE;
            fault_pol_r <= 1'b0;
            fault_sts_r <= 1'b0;
            ie_r <= 3'h0;
            ovf_r <= 3'h0;
            pol_sw_r <= 3'h0;
            for (j = 0; j < 3; j = j + 1) begin
                cks_sw_r[j] <= 2'b00;
                per_sw_r[j] <= 12'h000;
                duty_sw_r[j] <= 12'h000;
            end
        end else begin
            en_r <= en_nxt;
            if (reg_wr && reg_addr == `PWT_ADDR_LOCK) begin
                lock_r <= reg_wdata;
            end
            for (j = 0; j < 3; j = j + 1) begin
                if (ctl_wr_w[j]) begin
                    ie_r[j] <= reg_wdata[`PWT_CTL_IE];
                    pol_sw_r[j] <= reg_wdata[`PWT_CTL_POL];
                    cks_sw_r[j] <= reg_wdata[`PWT_CTL_CKS_HI:`PWT_CTL_CKS_LO];
                end
                ovf_r[j] <= ovf_nxt[j];
            end
            if (ctl_wr_w[0]) begin
                fault_pol_r <= reg_wdata[`PWT_CTL_FLT_POL];
            end
            fault_sts_r <= fault_sts_nxt;
            if (reg_wr && lock_ok) begin
                if (reg_addr == `PWT_ADDR_PER_MAIN_LO) begin
                    per_sw_r[0][7:0] <= reg_wdata;
                end else if (reg_addr == `PWT_ADDR_PER_MAIN_HI) begin
                    per_sw_r[0][11:8] <= reg_wdata[3:0];
                end else if (reg_addr == `PWT_ADDR_DUTY_MAIN_LO) begin
                    duty_sw_r[0][7:0] <= reg_wdata;
                end else if (reg_addr == `PWT_ADDR_DUTY_MAIN_HI) begin
                    duty_sw_r[0][11:8] <= reg_wdata[3:0];
                end else if (reg_addr == `PWT_ADDR_PER_AUX_A) begin
                    per_sw_r[1] <= {4'h0, reg_wdata};
                end else if (reg_addr == `PWT_ADDR_DUTY_AUX_A) begin
                    duty_sw_r[1] <= {4'h0, reg_wdata};
                end else if (reg_addr == `PWT_ADDR_PER_AUX_B) begin
                    per_sw_r[2] <= {4'h0, reg_wdata};
                end else if (reg_addr == `PWT_ADDR_DUTY_AUX_B) begin
                    duty_sw_r[2] <= {4'h0, reg_wdata};
                end
            end
        end
    end

    // ==========================================================
    // channel counters and working copies
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_r <= 4'h0;
            pol_r <= 3'h0;
            hold_r <= 3'h0;
            for (k = 0; k < 3; k = k + 1) begin
                cks_r[k] <= 2'b00;
                per_r[k] <= 12'h000;
                duty_r[k] <= 12'h000;
                cnt_r[k] <= 12'h000;
            end
        end else begin
            pre_r <= pre_r + 4'h1;
            for (k = 0; k < 3; k = k + 1) begin
                // copies taken only between periods so a running wave never tears
                if (load_w[k]) begin
                    pol_r[k] <= pol_sw_r[k];
                    cks_r[k] <= cks_sw_r[k];
                    per_r[k] <= per_sw_r[k];
                    duty_r[k] <= duty_sw_r[k];
                end
                cnt_r[k] <= cnt_nxt[k];
                hold_r[k] <= hold_nxt[k];
            end
        end
    end

    // ==========================================================
    // pins, enable delay, interrupt and read data
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st1_r <= 6'h00;
            st2_r <= 6'h00;
            pwm_out <= 3'h0;
            comp_out <= 3'h0;
            pwm_out_oe <= 3'h0;
            comp_out_oe <= 3'h0;
            fault_pin_claim <= 1'b0;
            pwm_irq <= 1'b0;
            reg_rdata <= `PWT_RST_BYTE;
        end else begin
            st1_r <= en_r[5:0];
            st2_r <= st1_r & en_r[5:0];
            // third edge after the set, dropped on the clearing edge
            pwm_out_oe <= en_nxt[`PWT_EN_PRIM_HI:0] & st2_r[2:0];
            comp_out_oe <= en_nxt[5:`PWT_EN_COMP_LO] & st2_r[5:3];
            fault_pin_claim <= en_r[`PWT_EN_FAULT];
            pwm_out <= pwm_nxt;
            comp_out <= comp_nxt;
            pwm_irq <= irq_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // read data, zero outside the cycle after a read
    always @* begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `PWT_ADDR_OUT_EN) begin
                rdata_nxt = {1'b0, en_r};
            end else if (reg_addr == `PWT_ADDR_CTL_MAIN) begin
                rdata_nxt = {ie_r[0], ovf_r[0], 1'b0, fault_sts_r, fault_pol_r,
                    pol_sw_r[0], cks_sw_r[0]};
            end else if (reg_addr == `PWT_ADDR_PER_MAIN_LO) begin
                rdata_nxt = per_sw_r[0][7:0];
            end else if (reg_addr == `PWT_ADDR_PER_MAIN_HI) begin
                rdata_nxt = {4'h0, per_sw_r[0][11:8]};
            end else if (reg_addr == `PWT_ADDR_DUTY_MAIN_LO) begin
                rdata_nxt = duty_sw_r[0][7:0];
            end else if (reg_addr == `PWT_ADDR_DUTY_MAIN_HI) begin
                rdata_nxt = {4'h0, duty_sw_r[0][11:8]};
            end else if (reg_addr == `PWT_ADDR_CTL_AUX_A) begin
                rdata_nxt = {ie_r[1], ovf_r[1], 3'h0, pol_sw_r[1], cks_sw_r[1]};
            end else if (reg_addr == `PWT_ADDR_PER_AUX_A) begin
                rdata_nxt = per_sw_r[1][7:0];
            end else if (reg_addr == `PWT_ADDR_DUTY_AUX_A) begin
                rdata_nxt = duty_sw_r[1][7:0];
            end else if (reg_addr == `PWT_ADDR_CTL_AUX_B) begin
                rdata_nxt = {ie_r[2], ovf_r[2], 3'h0, pol_sw_r[2], cks_sw_r[2]};
            end else if (reg_addr == `PWT_ADDR_PER_AUX_B) begin
                rdata_nxt = per_sw_r[2][7:0];
            end else if (reg_addr == `PWT_ADDR_DUTY_AUX_B) begin
                rdata_nxt = duty_sw_r[2][7:0];
            end else if (reg_addr == `PWT_ADDR_LOCK) begin
                rdata_nxt = lock_r;
            end
        end
    end

endmodule

// ==== tb/pwt_monitor.sv ====
// checker bound to the pwm timer unit top ports
`timescale 1ns/1ns
`include "pwt_defines.vh"
module pwt_monitor (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // interrupt and fault
    input wire pwm_group_irq_enable,
    input wire pwm_irq,
    input wire fault_pin,
    input wire fault_pin_claim,
    // pwm pins
    input wire [2:0] pwm_out,
    input wire [2:0] pwm_out_oe,
    input wire [2:0] comp_out,
    input wire [2:0] comp_out_oe
);
    reg [7:0] lock_r;
    reg [6:0] en_r;
    reg fpol_r;
    reg flt_seen_r;
    wire open_w = reg_wr && lock_r == `PWT_LOCK_KEY;
    wire flt_w = en_r[6] && fault_pin == fpol_r;
    wire [5:0] oe_w = {comp_out_oe, pwm_out_oe};
    // ==========================================================
    // shadow of lock, enable and fault level
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lock_r <= 8'h00;
            en_r <= 7'h00;
            fpol_r <= 1'b0;
            flt_seen_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `PWT_ADDR_LOCK) lock_r <= reg_wdata;
            if (open_w && reg_addr == `PWT_ADDR_OUT_EN) en_r <= reg_wdata[6:0];
            if (open_w && reg_addr == `PWT_ADDR_CTL_MAIN) fpol_r <= reg_wdata[3];
            if (flt_w) flt_seen_r <= 1'b1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // properties
    genvar i;
    for (i = 0; i < 6; i = i + 1) begin : g_pin
        a_oe_start: assert property ($rose(en_r[i]) |-> !oe_w[i] [*3] ##1 oe_w[i])
            else $error("pin drive did not start three clocks after enable");
        a_oe_stop: assert property ($fell(en_r[i]) |-> !oe_w[i])
            else $error("pin drive did not stop with its enable");
        a_oe_needs_en: assert property (oe_w[i] |-> $past(en_r[i], 3))
            else $error("pin driven without an accepted enable");
    end
    a_claim_copy: assert property (fault_pin_claim == $past(en_r[6]))
        else $error("fault pin claim does not follow its enable");
    a_fault_inactive: assert property (flt_w |-> ##2 pwm_out == comp_out)
        else $error("outputs not inactive after fault");
    a_comp_pair: assert property (!flt_seen_r && !$past(rst) && !$past(rst, 2)
        |-> comp_out == ~pwm_out)
        else $error("complementary output not inverse of primary");
    a_irq_gate: assert property (!pwm_group_irq_enable |=> !pwm_irq)
        else $error("interrupt raised with group enable low");
    a_irq_cause: assert property ($rose(pwm_irq) |-> $past(pwm_group_irq_enable))
        else $error("interrupt rose without group enable");
    a_hi_nibble: assert property ($past(reg_rd) && $past(reg_addr) == `PWT_ADDR_PER_MAIN_HI
        |-> reg_rdata[7:4] == 4'h0)
        else $error("period high register upper bits not zero");
endmodule

// ==== tb/pwt_power_stage.sv ====
// power switching stage and fault sensor at the pwm pins
`timescale 1ns/1ns
module pwt_power_stage #(
    parameter [0:0] ACTIVE_LEVEL = 1'b1
) (
    // clock
    input wire sys_clk,
    // pwm pins
    input wire [2:0] pwm_out,
    input wire [2:0] pwm_out_oe,
    input wire [2:0] comp_out,
    input wire [2:0] comp_out_oe,
    // sensor
    input wire trip,
    output wire fault_pin,
    output integer shoot_cnt
);
    // both switches of one leg on together is a short
    wire [2:0] short_w = pwm_out & pwm_out_oe & comp_out & comp_out_oe;
    initial shoot_cnt = 0;
    always @(posedge sys_clk) if (|short_w) shoot_cnt <= shoot_cnt + 1;
    // sensor has no pull, so it always drives its pin
    assign fault_pin = trip ? ACTIVE_LEVEL : ~ACTIVE_LEVEL;
endmodule

// ==== tb/tb_pwm_timer_unit_with_fault_lock.sv ====
// self-checking testbench of the pwm timer unit
`timescale 1ns/1ns
`include "pwt_defines.vh"
module tb_pwm_timer_unit_with_fault_lock;
    reg sys_clk, rst, reg_wr, reg_rd, pwm_group_irq_enable, trip;
    reg [7:0] reg_addr, reg_wdata;
    wire [7:0] reg_rdata;
    wire pwm_irq, fault_pin;
    wire [2:0] pwm_out, pwm_out_oe, comp_out, comp_out_oe;
    integer shoot_cnt, err_count, checked, cyc, i, b;
    localparam [79:0] RST_MAP = {8'h10, `PWT_ADDR_OUT_EN, `PWT_ADDR_CTL_MAIN,
        `PWT_ADDR_PER_MAIN_LO, `PWT_ADDR_PER_MAIN_HI, `PWT_ADDR_DUTY_MAIN_LO,
        `PWT_ADDR_DUTY_MAIN_HI, `PWT_ADDR_CTL_AUX_A, `PWT_ADDR_CTL_AUX_B, `PWT_ADDR_LOCK};
    // aux b cases: control, period, duty, high count, rise count
    localparam [159:0] AUXB = {8'h04, 8'h04, 8'h01, 8'd96, 8'd16, 8'h00, 8'h04, 8'h04, 8'd128,
        8'd0, 8'h04, 8'h00, 8'h03, 8'd128, 8'd0, 8'h00, 8'h00, 8'h03, 8'd0, 8'd0};
    pwt_top DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pwm_group_irq_enable(pwm_group_irq_enable), .pwm_irq(pwm_irq),
        .fault_pin(fault_pin), .fault_pin_claim(), .pwm_out(pwm_out),
        .pwm_out_oe(pwm_out_oe), .comp_out(comp_out), .comp_out_oe(comp_out_oe));
    pwt_power_stage u_stage (.sys_clk(sys_clk), .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe),
        .comp_out(comp_out), .comp_out_oe(comp_out_oe), .trip(trip),
        .fault_pin(fault_pin), .shoot_cnt(shoot_cnt));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // access and compare tasks
    task chk(input [15:0] exp, input [15:0] got, input string what);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected %0s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a, input [7:0] exp);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1;
            chk(exp, reg_rdata, $sformatf("register %h", a));
        end
    endtask
    task meas(input integer ch, input integer n, input integer hi, input integer rs);
        integer h, r;
        reg p;
        begin
            h = 0;
            r = 0;
            @(posedge sys_clk);
            #1 p = pwm_out[ch];
            repeat (n) begin
                @(posedge sys_clk);
                #1 h = h + pwm_out[ch];
                if (pwm_out[ch] && !p) r = r + 1;
                p = pwm_out[ch];
            end
            chk(hi, h, "high count");
            chk(rs, r, "rise count");
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d, mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            summarize;
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        {rst, reg_wr, reg_rd, pwm_group_irq_enable, trip} = 5'b10000;
        {reg_addr, reg_wdata} = 16'h0000;
        {err_count, checked, cyc} = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 10; i = i + 1) rd_reg(RST_MAP[8*i +: 8], 8'h00);
        wr_reg(`PWT_ADDR_PER_MAIN_LO, 8'h12);
        rd_reg(`PWT_ADDR_PER_MAIN_LO, 8'h00);
        wr_reg(`PWT_ADDR_LOCK, `PWT_LOCK_KEY);
        wr_reg(`PWT_ADDR_PER_MAIN_HI, 8'hff);
        rd_reg(`PWT_ADDR_PER_MAIN_HI, 8'h0f);
        wr_reg(`PWT_ADDR_PER_MAIN_LO, 8'h00);
        wr_reg(`PWT_ADDR_PER_MAIN_HI, 8'h01);
        wr_reg(`PWT_ADDR_DUTY_MAIN_LO, 8'h40);
        wr_reg(`PWT_ADDR_DUTY_MAIN_HI, 8'h00);
        wr_reg(`PWT_ADDR_CTL_MAIN, 8'h08);
        wr_reg(`PWT_ADDR_OUT_EN, 8'h09);
        repeat (520) @(posedge sys_clk);
        meas(0, 1024, 256, 2);
        wr_reg(`PWT_ADDR_PER_AUX_A, 8'h04);
        wr_reg(`PWT_ADDR_DUTY_AUX_A, 8'h01);
        wr_reg(`PWT_ADDR_OUT_EN, 8'h0b);
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(`PWT_ADDR_CTL_AUX_A, i[7:0]);
            repeat (130) @(posedge sys_clk);
            meas(1, 128, 32, 16 >> i);
        end
        for (i = 0; i < 4; i = i + 1) begin
            b = 40 * i;
            wr_reg(`PWT_ADDR_OUT_EN, 8'h0b);
            wr_reg(`PWT_ADDR_CTL_AUX_B, AUXB[b+32 +: 8]);
            wr_reg(`PWT_ADDR_PER_AUX_B, AUXB[b+24 +: 8]);
            wr_reg(`PWT_ADDR_DUTY_AUX_B, AUXB[b+16 +: 8]);
            wr_reg(`PWT_ADDR_OUT_EN, 8'h0f);
            repeat (130) @(posedge sys_clk);
            meas(2, 128, AUXB[b+8 +: 8], AUXB[b +: 8]);
        end
        wr_reg(`PWT_ADDR_CTL_AUX_A, 8'h80);
        repeat (20) @(posedge sys_clk);
        #1 chk(0, pwm_irq, "interrupt");
        pwm_group_irq_enable <= 1'b1;
        repeat (80) @(posedge sys_clk);
        #1 chk(1, pwm_irq, "interrupt");
        rd_reg(`PWT_ADDR_CTL_AUX_A, 8'hc0);
        wr_reg(`PWT_ADDR_OUT_EN, 8'h0d);
        wr_reg(`PWT_ADDR_CTL_AUX_A, 8'h80);
        rd_reg(`PWT_ADDR_CTL_AUX_A, 8'h80);
        repeat (3) @(posedge sys_clk);
        #1 chk(0, pwm_irq, "interrupt");
        pwm_group_irq_enable <= 1'b0;
        trip <= 1'b1;
        wr_reg(`PWT_ADDR_OUT_EN, 8'h02);
        repeat (130) @(posedge sys_clk);
        meas(1, 128, 32, 16);
        wr_reg(`PWT_ADDR_OUT_EN, 8'h42);
        repeat (4) @(posedge sys_clk);
        #1 chk(16'h0024, {comp_out, pwm_out}, "inactive outputs");
        rd_reg(`PWT_ADDR_CTL_MAIN, 8'h58);
        wr_reg(`PWT_ADDR_CTL_MAIN, 8'h08);
        rd_reg(`PWT_ADDR_CTL_MAIN, 8'h18);
        trip <= 1'b0;
        wr_reg(`PWT_ADDR_CTL_MAIN, 8'h08);
        rd_reg(`PWT_ADDR_CTL_MAIN, 8'h08);
        repeat (20) @(posedge sys_clk);
        meas(1, 128, 32, 16);
        wr_reg(`PWT_ADDR_LOCK, 8'h00);
        wr_reg(`PWT_ADDR_PER_MAIN_LO, 8'h77);
        rd_reg(`PWT_ADDR_PER_MAIN_LO, 8'h00);
        chk(0, shoot_cnt[15:0], "leg shorts");
        summarize;
    end
endmodule
bind pwt_top pwt_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_group_irq_enable(pwm_group_irq_enable), .pwm_irq(pwm_irq), .fault_pin(fault_pin),
    .fault_pin_claim(fault_pin_claim), .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe),
    .comp_out(comp_out), .comp_out_oe(comp_out_oe));
